// File: rtl/acc_conv_ctrl.sv
// Conversion controller top: registers, start sequencing, sleep handling and result formatting.
//
// Contract
// [R01] Sleep conversion only with RC clock selected.
// [R02] RC clock start waits one instruction cycle.
// [R03] Enabled interrupt wakes device after sleep conversion.
// [R04] Disabled interrupt powers down after sleep conversion.
// [R05] Non-RC clock: sleep aborts, powers down.
// [R06] Trigger sets start bit, resets timer.
// [R07] Software ensures timing under trigger starts.
// [R08] Software configures, enables, waits, then starts.
// [R09] Software polls start bit or awaits interrupt.
// [R10] Software clears interrupt flag after reading.
// [R11] Bit 7 selects right or left justify.
// [R12] Bits 6,5 select negative, positive references.
// [R13] Bits 4-2 select analog input 0-7.
// [R14] Start bit starts, reads busy, self-clears.
// [R15] Bit 0 enables converter; off draws nothing.
// [R16] Clock field divides system clock or selects RC.
// [R17] Unused clock register bits read zero.
// [R18] Left justify: bits 9-2 high, 1-0 low top.
// [R19] Right justify: bits 9-8 high low, 7-0 low.
// [R20] Conversion takes eleven bit periods.
// [R21] Completion clears start, sets flag, loads result.
// [R22] Software abort keeps result, waits two periods.
// [R23] Flag set on every completion.
// [R24] Core driven by start pulse, done, result.
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ns
module acc_conv_ctrl #(
    parameter int RES_W = acc_pkg::RESULT_BITS
)
(
    // Clock and reset.
    input  wire logic                   mclk,
    input  wire logic                   rst_n,
    // Register port.
    input  wire logic [1:0]             regAddr,
    input  wire logic [7:0]             regWdata,
    input  wire logic                   regWrite,
    input  wire logic                   regRead,
    output logic      [7:0]             regRdata,
    // System status and interrupt handshake.
    input  wire logic                   sleepMode,
    input  wire logic                   convIrqEnable,
    input  wire logic                   convIrqFlagClr,
    output logic                        convIrqFlag,
    output logic                        wakeRequest,
    // Special event trigger and timer reset.
    input  wire logic                   eventTrigger,
    output logic                        triggerTimerClr,
    // Internal RC oscillator pin level, asynchronous.
    input  wire logic                   rcOscIn,
    // Analog core.
    output acc_pkg::acc_analog_cfg_s    analogCfg,
    output logic                        coreStart,
    output logic                        coreBitStep,
    input  wire logic                   coreDone,
    input  wire logic [RES_W-1:0]       coreResult
);

    // Register state.
    logic [7:0]        ctrl_r;
    logic [2:0]        clkSel_r;
    logic [7:0]        resHi_r;
    logic [7:0]        resLo_r;
    logic [7:0]        rdata_r;
    logic              irqFlag_r;
    logic              wake_r;
    logic              timerClr_r;
    logic              coreStart_r;
    logic              bitStep_r;
    logic              powerOff_r;
    acc_pkg::acc_analog_cfg_s cfg_r;
    acc_pkg::acc_state_e state_r;
    acc_pkg::acc_state_e state_nxt;
    logic [3:0]        periodCnt_r;
    logic [1:0]        delayCnt_r;
    logic              rcSync1_r;
    logic              rcSync2_r;
    logic              eventSync1_r;
    logic              eventSync2_r;
    logic              eventPrev_r;
    logic              sleepSync1_r;
    logic              sleepSync2_r;
    logic              periodTick;

    // Field decode of the control registers.
    wire logic       enableBit   = ctrl_r[acc_pkg::BIT_ENABLE];
    wire logic       startBit    = ctrl_r[acc_pkg::BIT_START];
    wire logic       justifyRight = ctrl_r[acc_pkg::BIT_JUSTIFY];
    wire logic       useRc       = (clkSel_r[1:0] == acc_pkg::CLK_RC_LOW); // [R16]

    // Bus decode.
    wire logic       wrCtrl      = regWrite && (regAddr == acc_pkg::ADDR_CTRL);
    wire logic       wrClk       = regWrite && (regAddr == acc_pkg::ADDR_CLKSEL);
    wire logic       wrHi        = regWrite && (regAddr == acc_pkg::ADDR_RESHI);
    wire logic       wrLo        = regWrite && (regAddr == acc_pkg::ADDR_RESLO);
    wire logic       swStart     = wrCtrl && regWdata[acc_pkg::BIT_START] && regWdata[acc_pkg::BIT_ENABLE];
    wire logic       swAbort     = wrCtrl && !regWdata[acc_pkg::BIT_START] && startBit;
    wire logic       trigRise    = eventSync2_r && !eventPrev_r;
    wire logic       hwStart     = trigRise && enableBit; // [R06]

    // Sequencer events.
    wire logic       busy        = (state_r == acc_pkg::ST_DELAY) || (state_r == acc_pkg::ST_CONVERT);
    wire logic       sleepAbort  = sleepSync2_r && busy && !useRc; // [R05] [R01]
    wire logic       convDone    = (state_r == acc_pkg::ST_CONVERT) && periodTick
                                   && (periodCnt_r == acc_pkg::CONV_PERIODS - 4'h1); // [R20]
    wire logic       doneEvent   = convDone && coreDone; // [R24]
    wire logic       abortDone   = (state_r == acc_pkg::ST_ABORT_WAIT) && periodTick
                                   && (periodCnt_r == acc_pkg::ABORT_PERIODS - 4'h1); // [R22]
    wire logic       tickRun     = (state_r == acc_pkg::ST_CONVERT) || (state_r == acc_pkg::ST_ABORT_WAIT);

    // Result packing for the two justifications.
    wire logic [7:0] fmtHi = justifyRight ? {6'h00, coreResult[9:8]} : coreResult[9:2]; // [R19] [R18]
    wire logic [7:0] fmtLo = justifyRight ? coreResult[7:0] : {coreResult[1:0], 6'h00}; // [R19] [R18]

    // Half period for the selected division.
    logic [5:0] halfCount;
    always_comb
    begin
        case (clkSel_r) // [R16]
            acc_pkg::CLK_DIV2:  halfCount = acc_pkg::HALF_DIV2;
            acc_pkg::CLK_DIV4:  halfCount = acc_pkg::HALF_DIV4;
            acc_pkg::CLK_DIV8:  halfCount = acc_pkg::HALF_DIV8;
            acc_pkg::CLK_DIV16: halfCount = acc_pkg::HALF_DIV16;
            acc_pkg::CLK_DIV32: halfCount = acc_pkg::HALF_DIV32;
            acc_pkg::CLK_DIV64: halfCount = acc_pkg::HALF_DIV64;
            default:            halfCount = acc_pkg::HALF_DIV2;
        endcase
    end

    // Read multiplexer; unused clock register bits always read zero.
    logic [7:0] rdMux;
    always_comb
    begin
        case (regAddr)
            acc_pkg::ADDR_CTRL:   rdMux = ctrl_r;
            acc_pkg::ADDR_CLKSEL: rdMux = {1'b0, clkSel_r, 4'h0} & acc_pkg::CLKSEL_MASK; // [R17]
            acc_pkg::ADDR_RESHI:  rdMux = resHi_r;
            acc_pkg::ADDR_RESLO:  rdMux = resLo_r;
            default:              rdMux = 8'h00;
        endcase
    end

    // Next state of the start sequencer.
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            acc_pkg::ST_IDLE:
            begin
                if (swStart || hwStart || startBit)
                    state_nxt = useRc ? acc_pkg::ST_DELAY : acc_pkg::ST_CONVERT; // [R02]
            end
            acc_pkg::ST_DELAY:
            begin
                if (delayCnt_r == acc_pkg::INSTR_CYCLES)
                    state_nxt = acc_pkg::ST_CONVERT; // [R02]
            end
            acc_pkg::ST_CONVERT:
            begin
                if (convDone)
                    state_nxt = (sleepSync2_r && !convIrqEnable) ? acc_pkg::ST_SLEEP_OFF : acc_pkg::ST_IDLE; // [R04]
            end
            acc_pkg::ST_ABORT_WAIT:
            begin
                if (abortDone)
                    state_nxt = acc_pkg::ST_IDLE; // [R22]
            end
            acc_pkg::ST_SLEEP_OFF:
            begin
                if (!sleepSync2_r)
                    state_nxt = acc_pkg::ST_IDLE;
            end
            default: state_nxt = acc_pkg::ST_IDLE;
        endcase
        if (!enableBit)
            state_nxt = acc_pkg::ST_IDLE; // [R15]
        else if (sleepAbort)
            state_nxt = acc_pkg::ST_SLEEP_OFF; // [R05]
        else if (swAbort && busy)
            state_nxt = acc_pkg::ST_ABORT_WAIT; // [R22]
    end

    // Synchronisers for pins from outside the clock domain.
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            {rcSync1_r, rcSync2_r}       <= 2'h0;
            {eventSync1_r, eventSync2_r} <= 2'h0;
            {sleepSync1_r, sleepSync2_r} <= 2'h0;
            eventPrev_r                  <= 1'b0;
        end
        else
        begin
            {rcSync1_r, rcSync2_r}       <= {rcOscIn, rcSync1_r};
            {eventSync1_r, eventSync2_r} <= {eventTrigger, eventSync1_r};
            {sleepSync1_r, sleepSync2_r} <= {sleepMode, sleepSync1_r};
            eventPrev_r                  <= eventSync2_r;
        end
    end

    // Sequencer state, period and delay counters.
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            state_r     <= acc_pkg::ST_IDLE;
            periodCnt_r <= 4'h0;
            delayCnt_r  <= 2'h0;
        end
        else
        begin
            state_r     <= state_nxt;
            periodCnt_r <= (state_nxt != state_r) ? 4'h0 : periodCnt_r + {3'h0, periodTick};
            delayCnt_r  <= (state_r == acc_pkg::ST_DELAY) ? delayCnt_r + 2'h1 : 2'h0;
        end
    end

    // Control register; hardware set or clear of the start bit wins over software.
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            ctrl_r <= acc_pkg::CTRL_RESET;
        else
        begin
            if (wrCtrl)
                ctrl_r <= regWdata; // [R11] [R12] [R13]
            if (hwStart)
                ctrl_r[acc_pkg::BIT_START] <= 1'b1; // [R06] [R14]
            else if (convDone || sleepAbort || (wrCtrl && !regWdata[acc_pkg::BIT_ENABLE]))
                ctrl_r[acc_pkg::BIT_START] <= 1'b0; // [R14] [R21]
        end
    end

    // Clock select and result registers; completion load beats a software write.
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            clkSel_r <= acc_pkg::CLKSEL_RESET;
            resHi_r  <= 8'h00;
            resLo_r  <= 8'h00;
        end
        else
        begin
            if (wrClk)
                clkSel_r <= regWdata[acc_pkg::BIT_CLK_HI:acc_pkg::BIT_CLK_LO];
            if (doneEvent)
            begin
                resHi_r <= fmtHi; // [R21]
                resLo_r <= fmtLo; // [R21]
            end
            else
            begin
                if (wrHi)
                    resHi_r <= regWdata;
                if (wrLo)
                    resLo_r <= regWdata;
            end
        end
    end

    // Interrupt flag, wake request and one-cycle strobes; set wins over clear.
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            irqFlag_r   <= 1'b0;
            wake_r      <= 1'b0;
            timerClr_r  <= 1'b0;
            coreStart_r <= 1'b0;
            bitStep_r   <= 1'b0;
            rdata_r     <= 8'h00;
        end
        else
        begin
            irqFlag_r   <= convDone ? 1'b1 : (convIrqFlagClr ? 1'b0 : irqFlag_r); // [R23] [R21]
            wake_r      <= convDone && sleepSync2_r && convIrqEnable; // [R03]
            timerClr_r  <= trigRise; // [R06]
            coreStart_r <= (state_r != acc_pkg::ST_CONVERT) && (state_nxt == acc_pkg::ST_CONVERT); // [R24]
            bitStep_r   <= periodTick && (state_r == acc_pkg::ST_CONVERT) && (state_nxt == state_r); // [R24]
            rdata_r     <= regRead ? rdMux : 8'h00;
        end
    end

    // Analog configuration; power drops when disabled or parked by sleep, enable bit untouched.
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            cfg_r      <= '0;
            powerOff_r <= 1'b0;
        end
        else
        begin
            powerOff_r       <= (state_nxt == acc_pkg::ST_SLEEP_OFF); // [R04] [R05]
            cfg_r.negRefSel  <= ctrl_r[acc_pkg::BIT_NEGREF]; // [R12]
            cfg_r.posRefSel  <= ctrl_r[acc_pkg::BIT_POSREF]; // [R12]
            cfg_r.channelSel <= ctrl_r[acc_pkg::BIT_CHAN_HI:acc_pkg::BIT_CHAN_LO]; // [R13]
            cfg_r.powerOn    <= enableBit && (state_nxt != acc_pkg::ST_SLEEP_OFF); // [R15] [R04] [R05]
        end
    end

    // Period tick generator; counter held clear outside conversions and abort waits to keep divided-clock conversion periods whole.
    acc_period_tick #(
        .HALF_W (6)
    ) u_tick (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .run        (tickRun),
        .useRc      (useRc),
        .halfCount  (halfCount),
        .rcLevel    (rcSync2_r),
        .periodTick (periodTick)
    );

    assign regRdata        = rdata_r;
    assign convIrqFlag     = irqFlag_r;
    assign wakeRequest     = wake_r;
    assign triggerTimerClr = timerClr_r;
    assign coreStart       = coreStart_r;
    assign coreBitStep     = bitStep_r;
    assign analogCfg       = cfg_r;

endmodule : acc_conv_ctrl

// File: rtl/acc_period_tick.sv
// Bit conversion period tick generator: divides the system clock or samples the RC clock.
`timescale 1ns/1ns
module acc_period_tick #(
    parameter int HALF_W = 6
)
(
    // Clock and reset.
    input  wire logic              mclk,
    input  wire logic              rst_n,
    // Control.
    input  wire logic              run,
    input  wire logic              useRc,
    input  wire logic [HALF_W-1:0] halfCount,
    // Already synchronised RC oscillator level.
    input  wire logic              rcLevel,
    // One-cycle pulse per bit conversion period.
    output logic                   periodTick
);

    logic [HALF_W:0] cnt_r;
    logic            rcPrev_r;
    logic            tick_r;

    // Full period of the divided clock is twice the half count.
    wire logic [HALF_W:0] fullCount = {halfCount, 1'b0};
    wire logic            divDone   = (cnt_r + 1'b1) >= fullCount;
    wire logic            rcRise    = rcLevel & ~rcPrev_r;

    // Counter restarts whenever the sequencer is idle so every divided-clock conversion period is whole.
    always_ff @(posedge mclk)
    begin
        if (!rst_n || !run)
        begin
            cnt_r  <= '0;
            tick_r <= 1'b0;
        end
        else
        begin
            cnt_r  <= divDone ? '0 : cnt_r + 1'b1;
            tick_r <= useRc ? rcRise : divDone;
        end
    end

    // Previous RC level for rising edge detection.
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            rcPrev_r <= 1'b0;
        else
            rcPrev_r <= rcLevel;
    end

    assign periodTick = tick_r;

endmodule : acc_period_tick

// File: rtl/acc_pkg.sv
// Package with register map, field layout, encodings and timing for the conversion controller.
package acc_pkg;

    // Register indices on the plain register port.
    localparam logic [1:0] ADDR_CTRL   = 2'h0;
    localparam logic [1:0] ADDR_CLKSEL = 2'h1;
    localparam logic [1:0] ADDR_RESHI  = 2'h2;
    localparam logic [1:0] ADDR_RESLO  = 2'h3;

    // Control register field positions.
    localparam int BIT_JUSTIFY  = 7;
    localparam int BIT_NEGREF   = 6;
    localparam int BIT_POSREF   = 5;
    localparam int BIT_CHAN_HI  = 4;
    localparam int BIT_CHAN_LO  = 2;
    localparam int BIT_START    = 1;
    localparam int BIT_ENABLE   = 0;

    // Clock select field position in the second control register.
    localparam int BIT_CLK_HI   = 6;
    localparam int BIT_CLK_LO   = 4;

    // Reset values.
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam logic [2:0] CLKSEL_RESET = 3'h0;
    localparam logic [7:0] CLKSEL_MASK  = 8'h70;

    // Clock select codes; the internal RC choice is any code whose low two bits are set.
    localparam logic [2:0] CLK_DIV2  = 3'h0;
    localparam logic [2:0] CLK_DIV4  = 3'h4;
    localparam logic [2:0] CLK_DIV8  = 3'h1;
    localparam logic [2:0] CLK_DIV16 = 3'h5;
    localparam logic [2:0] CLK_DIV32 = 3'h2;
    localparam logic [2:0] CLK_DIV64 = 3'h6;
    localparam logic [1:0] CLK_RC_LOW = 2'h3;

    // Half-period counts of the system clock divider, one per division.
    localparam logic [5:0] HALF_DIV2  = 6'h01;
    localparam logic [5:0] HALF_DIV4  = 6'h02;
    localparam logic [5:0] HALF_DIV8  = 6'h04;
    localparam logic [5:0] HALF_DIV16 = 6'h08;
    localparam logic [5:0] HALF_DIV32 = 6'h10;
    localparam logic [5:0] HALF_DIV64 = 6'h20;

    // Conversion timing in bit conversion periods.
    localparam logic [3:0] CONV_PERIODS  = 4'hB;
    localparam logic [3:0] ABORT_PERIODS = 4'h2;
    localparam int         RESULT_BITS   = 10;

    // Extra instruction cycle before a start when the RC clock is used, in system clocks.
    localparam logic [1:0] INSTR_CYCLES = 2'h3;

    // Sequencer states.
    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_DELAY,
        ST_CONVERT,
        ST_ABORT_WAIT,
        ST_SLEEP_OFF
    } acc_state_e;

    // Configuration handed to the analog core.
    typedef struct packed
    {
        logic       negRefSel;
        logic       posRefSel;
        logic [2:0] channelSel;
        logic       powerOn;
    } acc_analog_cfg_s;

endpackage : acc_pkg

// File: tb/acc_conv_ctrl_asserts.sv
// Checker for the port behaviour of the conversion controller.
`timescale 1ns/1ns
module acc_conv_ctrl_asserts
(
    // Clock and reset.
    input wire logic                     mclk,
    input wire logic                     rst_n,
    // Register port.
    input wire logic [1:0]               regAddr,
    input wire logic [7:0]               regWdata,
    input wire logic                     regWrite,
    input wire logic                     regRead,
    input wire logic [7:0]               regRdata,
    // Interrupt and trigger handshake.
    input wire logic                     convIrqEnable,
    input wire logic                     convIrqFlagClr,
    input wire logic                     convIrqFlag,
    input wire logic                     wakeRequest,
    input wire logic                     triggerTimerClr,
    // Analog core side.
    input wire acc_pkg::acc_analog_cfg_s analogCfg,
    input wire logic                     coreStart,
    input wire logic                     coreBitStep
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // Read data must not leak outside the answer cycle of a read.
    rdata_idle_a: assert property (!$past(regRead) |-> regRdata == 8'h00)
        else $error("read data not zero outside a read answer");
    flag_hold_a: assert property (convIrqFlag && !convIrqFlagClr |=> convIrqFlag)
        else $error("completion flag dropped without a clear");
    timer_pulse_a: assert property (triggerTimerClr |=> !triggerTimerClr)
        else $error("trigger timer clear longer than one cycle");
    wake_cause_a: assert property (wakeRequest |-> $past(convIrqEnable))
        else $error("wake request with interrupt disabled");
    step_power_a: assert property (coreBitStep |-> analogCfg.powerOn)
        else $error("bit step while converter powered down");
    start_power_a: assert property (coreStart |-> analogCfg.powerOn)
        else $error("core start while converter powered down");
    // A new start cannot follow within eight cycles of a start.
    start_gap_a: assert property (coreStart |=> !coreStart [*8])
        else $error("core start repeated too soon");
    cfg_follow_a: assert property (regWrite && regAddr == acc_pkg::ADDR_CTRL |=> ##1
        {1'b0, analogCfg.negRefSel, analogCfg.posRefSel, analogCfg.channelSel, 2'b00} == ($past(regWdata, 2) & 8'h7C))
        else $error("analog configuration not taken from control write");
    power_off_a: assert property (regWrite && regAddr == acc_pkg::ADDR_CTRL && !regWdata[0]
        |=> ##1 !analogCfg.powerOn)
        else $error("converter still powered after disable");

    // Main scenarios.
    start_c: cover property (coreStart);
    wake_c: cover property (wakeRequest);
    trig_c: cover property (triggerTimerClr);
endmodule : acc_conv_ctrl_asserts

// File: tb/acc_conv_ctrl_test.sv
// Self-checking bench for the conversion controller.
`timescale 1ns/1ns
module acc_conv_ctrl_test;
    logic                     mclk = 1'b0;
    logic                     rst_n = 1'b0;
    logic                     rcOscIn = 1'b0;
    logic [1:0]               regAddr = 2'h0;
    logic [7:0]               regWdata = 8'h00;
    logic                     regWrite = 1'b0;
    logic                     regRead = 1'b0;
    logic                     sleepMode = 1'b0;
    logic                     convIrqEnable = 1'b0;
    logic                     convIrqFlagClr = 1'b0;
    logic                     eventTrigger = 1'b0;
    logic [9:0]               sample = 10'h000;
    logic [7:0]               regRdata, rdVal;
    logic                     convIrqFlag, wakeRequest, triggerTimerClr, coreStart, coreBitStep, coreDone, jr;
    logic [9:0]               coreResult, prev;
    acc_pkg::acc_analog_cfg_s analogCfg;
    int                       fails = 0, checks_done = 0, wakes = 0, clrs = 0, n, lo, hi;
    int                       per [8] = '{2, 4, 8, 16, 32, 64, 10, 10};
    logic [2:0]               code [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};

    // System clock at 25 MHz; the RC oscillator runs free at ten system periods.
    always #20 mclk = ~mclk;
    always #200 rcOscIn = ~rcOscIn;

    acc_conv_ctrl u_dut
    (
        .mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata), .sleepMode(sleepMode), .convIrqEnable(convIrqEnable),
        .convIrqFlagClr(convIrqFlagClr), .convIrqFlag(convIrqFlag), .wakeRequest(wakeRequest),
        .eventTrigger(eventTrigger), .triggerTimerClr(triggerTimerClr), .rcOscIn(rcOscIn),
        .analogCfg(analogCfg), .coreStart(coreStart), .coreBitStep(coreBitStep), .coreDone(coreDone),
        .coreResult(coreResult)
    );

    acc_core_model u_core
    (
        .mclk(mclk), .rst_n(rst_n), .cfg(analogCfg), .coreStart(coreStart), .coreBitStep(coreBitStep),
        .sample(sample), .coreDone(coreDone), .coreResult(coreResult)
    );

    // Pulses are counted here because they stand for one cycle only.
    always @(posedge mclk)
    begin
        if (wakeRequest === 1'b1)
            wakes <= wakes + 1;
        if (triggerTimerClr === 1'b1)
            clrs <= clrs + 1;
    end

    task automatic check(string what, logic [9:0] seen, logic [9:0] expv);
        checks_done++;
        if (seen !== expv)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, expv, seen);
        end
    endtask : check

    task automatic wr(logic [1:0] a, logic [7:0] d);
        @(posedge mclk);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask : wr

    task automatic ctrl(logic [7:0] d);
        wr(acc_pkg::ADDR_CTRL, d);
    endtask : ctrl

    // Read data stand only in the cycle after the strobe, so sample mid-cycle.
    task automatic rdc(string what, logic [1:0] a, logic [7:0] e);
        @(posedge mclk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        @(negedge mclk);
        check(what, {2'b00, regRdata}, {2'b00, e});
    endtask : rdc

    task automatic clear_flag();
        @(posedge mclk);
        convIrqFlagClr <= 1'b1;
        @(posedge mclk);
        convIrqFlagClr <= 1'b0;
        @(negedge mclk);
    endtask : clear_flag

    task automatic wait_flag(output int cnt);
        cnt = 0;
        while (convIrqFlag !== 1'b1 && cnt < 2000)
        begin
            @(negedge mclk);
            cnt++;
        end
        if (cnt >= 2000)
        begin
            fails++;
            print_verdict();
        end
    endtask : wait_flag

    task automatic print_verdict();
        if (fails == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict

    initial
    begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        rdc("ctrlReset", acc_pkg::ADDR_CTRL, 8'h00);
        rdc("clkReset", acc_pkg::ADDR_CLKSEL, 8'h00);
        wr(acc_pkg::ADDR_CLKSEL, 8'hFF);
        rdc("clkUnused", acc_pkg::ADDR_CLKSEL, 8'h70);
        // Every clock code, channel and both justifications, polled to completion.
        for (int i = 0; i < 8; i++)
        begin
            sample = 10'h3A5 - 10'(i * 83);
            jr     = i[0];
            wr(acc_pkg::ADDR_CLKSEL, {1'b0, code[i], 4'h0});
            ctrl({jr, i[1:0], i[2:0], 2'b01});
            repeat (4) @(posedge mclk);
            ctrl({jr, i[1:0], i[2:0], 2'b11});
            rdc("busy", acc_pkg::ADDR_CTRL, {jr, i[1:0], i[2:0], 2'b11});
            wait_flag(n);
            lo = 11 * per[i] - ((i > 5) ? per[i] : 0);
            hi = 12 * per[i] + 12;
            check("convTime", 10'(n + 3 >= lo && n + 3 <= hi), 10'h001);
            rdc("doneBit", acc_pkg::ADDR_CTRL, {jr, i[1:0], i[2:0], 2'b01});
            rdc("resHigh", acc_pkg::ADDR_RESHI, jr ? {6'h00, sample[9:8]} : sample[9:2]);
            rdc("resLow", acc_pkg::ADDR_RESLO, jr ? sample[7:0] : {sample[1:0], 6'h00});
            clear_flag();
            check("flagClr", {9'h000, convIrqFlag}, 10'h000);
        end
        // Sleep conversions on the RC clock, with and without the interrupt enabled.
        for (int k = 0; k < 2; k++)
        begin
            convIrqEnable <= k[0];
            ctrl(8'h03);
            sleepMode <= 1'b1;
            wait_flag(n);
            repeat (3) @(posedge mclk);
            check("wakes", 10'(wakes), 10'(k));
            if (k == 0)
                check("sleepOff", {9'h000, analogCfg.powerOn}, 10'h000);
            rdc("sleepCtrl", acc_pkg::ADDR_CTRL, 8'h01);
            sleepMode <= 1'b0;
            clear_flag();
        end
        // Sleep on a divided clock aborts the conversion in progress.
        wr(acc_pkg::ADDR_CLKSEL, 8'h00);
        ctrl(8'h03);
        repeat (4) @(posedge mclk);
        sleepMode <= 1'b1;
        repeat (30) @(negedge mclk);
        check("abortFlag", {9'h000, convIrqFlag}, 10'h000);
        check("abortOff", {9'h000, analogCfg.powerOn}, 10'h000);
        rdc("abortCtrl", acc_pkg::ADDR_CTRL, 8'h01);
        sleepMode <= 1'b0;
        repeat (10) @(posedge mclk);
        // Software abort keeps the previous result.
        prev   = sample;
        sample = 10'h0F0;
        ctrl(8'h03);
        repeat (6) @(posedge mclk);
        ctrl(8'h01);
        repeat (30) @(negedge mclk);
        check("swAbortFlag", {9'h000, convIrqFlag}, 10'h000);
        rdc("keepHigh", acc_pkg::ADDR_RESHI, prev[9:2]);
        rdc("keepLow", acc_pkg::ADDR_RESLO, {prev[1:0], 6'h00});
        // Special event trigger starts a conversion and clears the trigger timer.
        ctrl(8'h00);
        ctrl(8'h01);
        eventTrigger <= 1'b1;
        repeat (8) @(posedge mclk);
        check("timerClr", 10'(clrs), 10'h001);
        rdc("trigBusy", acc_pkg::ADDR_CTRL, 8'h03);
        wait_flag(n);
        eventTrigger <= 1'b0;
        rdc("trigHigh", acc_pkg::ADDR_RESHI, sample[9:2]);
        print_verdict();
    end
endmodule : acc_conv_ctrl_test

bind acc_conv_ctrl acc_conv_ctrl_asserts u_chk
(
    .mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .convIrqEnable(convIrqEnable), .convIrqFlagClr(convIrqFlagClr),
    .convIrqFlag(convIrqFlag), .wakeRequest(wakeRequest), .triggerTimerClr(triggerTimerClr),
    .analogCfg(analogCfg), .coreStart(coreStart), .coreBitStep(coreBitStep)
);

// File: tb/acc_core_model.sv
// Behavioural model of the sample-and-hold and approximation core.
`timescale 1ns/1ns
module acc_core_model
(
    // Clock and reset.
    input  wire logic                     mclk,
    input  wire logic                     rst_n,
    // Control from the controller.
    input  wire acc_pkg::acc_analog_cfg_s cfg,
    input  wire logic                     coreStart,
    input  wire logic                     coreBitStep,
    // Value the bench wants converted.
    input  wire logic [9:0]               sample,
    // Answer to the controller.
    output logic                          coreDone,
    output logic [9:0]                    coreResult
);
    logic [3:0] steps_r;

    // One result bit per bit period; power loss restarts the approximation.
    always_ff @(posedge mclk)
        if (!rst_n || coreStart || !cfg.powerOn)
            steps_r <= 4'h0;
        else if (coreBitStep && steps_r != 4'hF)
            steps_r <= steps_r + 4'h1;

    // Before done the result lines carry the inverse, so a stale load cannot pass.
    assign coreDone   = steps_r >= 4'h9;
    assign coreResult = coreDone ? sample : ~sample;
endmodule : acc_core_model
